// ==== logic/logic_blocks_pkg.sv ====
// Shared types and constants for the user logic function blocks.
package logic_blocks_pkg;

  // ****************************************************************
  // Number format
  // ****************************************************************
  localparam int          FIX_W     = 32;
  localparam int          FRAC_W    = 16;
  localparam int          PROD_W    = 42;
  localparam logic [31:0] FRAC_MASK = 32'h0000ffff;
  localparam logic [31:0] HALF_UNIT = 32'h00008000;
  typedef logic signed [FIX_W-1:0] fix_type;

  // ****************************************************************
  // Comparators
  // ****************************************************************
  localparam logic [6:0]        HYST_MAX  = 7'h64;
  localparam logic signed [9:0] PCT_FULL  = 10'sh064;
  localparam logic [1:0]        CMP_LE    = 2'h0;
  localparam logic [1:0]        CMP_GT    = 2'h1;
  localparam logic [1:0]        CMP_LT    = 2'h2;
  localparam logic [1:0]        CMP_EQ    = 2'h3;

  typedef struct packed {
    fix_type    in1;
    fix_type    in2;
    logic [6:0] hyst_pct;
  } cmp_args_type;

  // ****************************************************************
  // Counter, timer and event codes
  // ****************************************************************
  localparam int         CNT_W     = 16;
  localparam int         DLY_W     = 16;
  localparam logic [15:0] CNT_ZERO = 16'h0000;

  typedef enum logic [3:0] {
    TMR_IDLE     = 4'h1,
    TMR_ON_WAIT  = 4'h2,
    TMR_ON       = 4'h4,
    TMR_OFF_WAIT = 4'h8
  } tmr_state_type;

  typedef struct packed {
    logic [18:0] spn;
    logic [4:0]  fmi;
  } dtc_type;

  // ****************************************************************
  // Calendar
  // ****************************************************************
  localparam int DATE_KEY_W = 38;

  typedef struct packed {
    logic [11:0] year;
    logic [3:0]  month;
    logic [4:0]  day;
    logic [4:0]  hour;
    logic [5:0]  minute;
    logic [5:0]  second;
  } date_type;

  // Bit 5 enables year, down to bit 0 for second.
  typedef struct packed {
    date_type   value;
    logic [5:0] used;
  } date_cfg_type;

endpackage

// ==== logic/hyst_compare.sv ====
// One magnitude comparator with a release band relative to input two.
`timescale 1ns/100ps
`default_nettype none
module hyst_compare
  import logic_blocks_pkg::*;
#(
  parameter logic [1:0] MODE = CMP_LE
) (
  input  wire logic         clock,       // evaluation clock
  input  wire logic         rst_sync_n,  // synchronised reset, active low
  input  wire logic         clear,       // synchronous clear
  input  wire cmp_args_type args,        // operands and hysteresis
  output var  logic         hit_q        // comparator result
);

  logic [6:0]          pct_c;
  logic signed [9:0]   up_f;
  logic signed [9:0]   dn_f;
  logic signed [PROD_W-1:0] p1;
  logic signed [PROD_W-1:0] hi;
  logic signed [PROD_W-1:0] lo;
  logic                set_c;
  logic                rel_c;

  always_comb begin
    pct_c = (args.hyst_pct > HYST_MAX) ? HYST_MAX : args.hyst_pct;
    up_f  = PCT_FULL + $signed({3'h0, pct_c});
    dn_f  = PCT_FULL - $signed({3'h0, pct_c});
    p1    = args.in1 * PCT_FULL;
    hi    = args.in2 * up_f;
    lo    = args.in2 * dn_f;
  end

  always_comb begin
    unique case (MODE)
      CMP_LE: begin
        set_c = args.in1 <= args.in2;
        rel_c = p1 > hi;
      end
      CMP_GT: begin
        set_c = args.in1 > args.in2;
        rel_c = p1 < lo;
      end
      CMP_LT: begin
        set_c = args.in1 < args.in2;
        rel_c = p1 > hi;
      end
      CMP_EQ: begin
        set_c = args.in1 == args.in2;
        rel_c = (p1 > hi) || (p1 < lo);
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      hit_q <= 1'b0;
    end else if (clear) begin
      hit_q <= 1'b0;
    end else begin
      // A set condition wins over a release that holds in the same tick.
      hit_q <= set_c || (hit_q && !rel_c);
    end
  end

  a_cmp_set: assert property (@(posedge clock) disable iff (!rst_sync_n)
    !clear && set_c |=> hit_q) else $error("comparator missed set");
  a_cmp_release: assert property (@(posedge clock) disable iff (!rst_sync_n)
    hit_q && !rel_c && !clear |=> hit_q)
    else $error("comparator released early");

endmodule // hyst_compare
`default_nettype wire

// ==== logic/logic_function_blocks.sv ====
// User logic engine primitives: comparators, counter, timer and more.
`timescale 1ns/100ps
`default_nettype none
module logic_function_blocks
  import logic_blocks_pkg::*;
(
  input  wire logic         clock,          // evaluation clock, 100 MHz
  input  wire logic         rst_n,          // async reset, active low
  input  wire logic         block_clear,    // synchronous clear of all
  input  wire cmp_args_type le_args,        // at-most operands
  input  wire cmp_args_type gt_args,        // greater operands
  input  wire cmp_args_type lt_args,        // less operands
  input  wire cmp_args_type eq_args,        // equality operands
  output var  logic         cmp_le_q,       // at-most result
  output var  logic         cmp_gt_q,       // greater result
  output var  logic         cmp_lt_q,       // less result
  output var  logic         cmp_eq_q,       // equality result
  input  wire logic         cnt_pulse,      // counted input
  input  wire logic         cnt_reset,      // counter reset input
  output var  logic [15:0]  count_q,        // edges counted
  input  wire logic         tmr_in,         // timer input
  input  wire logic [15:0]  tmr_on_delay,   // on delay in ticks
  input  wire logic [15:0]  tmr_off_delay,  // off delay in ticks
  output var  logic         tmr_out_q,      // timer output
  input  wire fix_type      res_in,         // residue input
  output var  fix_type      res_out_q,      // fractional part
  input  wire fix_type      rnd_in,         // rounding input
  output var  fix_type      rnd_out_q,      // rounded value
  input  wire fix_type      sel_a,          // selector input one
  input  wire fix_type      sel_b,          // selector input two
  input  wire logic         sel_pick,       // selector choice
  output var  fix_type      sel_out_q,      // selected value
  input  wire logic         evt_in,         // virtual event trigger
  input  wire dtc_type      evt_code,       // code to raise
  output var  logic         evt_raise_q,    // code raised
  output var  dtc_type      evt_code_q,     // code being raised
  input  wire dtc_type      mon_code,       // code to watch
  input  wire dtc_type      seen_code,      // code reported present
  input  wire logic         seen_valid,     // seen_code is present
  output var  logic         mon_hit_q,      // watched code present
  input  wire date_type     rtc_now,        // current calendar time
  input  wire date_cfg_type aoa_cfg,        // at-or-after setting
  input  wire date_cfg_type aob_cfg,        // at-or-before setting
  input  wire date_cfg_type sa_cfg,         // strictly-after setting
  output var  logic         date_at_or_after_q,    // clock >= setting
  output var  logic         date_at_or_before_q,   // clock <= setting
  output var  logic         date_strictly_after_q  // clock > setting
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_meta_q;
  logic rst_sync_q;
  logic rst_sync_n;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  assign rst_sync_n = rst_sync_q;

  // ****************************************************************
  // Magnitude comparators
  // ****************************************************************
  hyst_compare #(.MODE(CMP_LE)) u_cmp_le (
    .clock      (clock),
    .rst_sync_n (rst_sync_n),
    .clear      (block_clear),
    .args       (le_args),
    .hit_q      (cmp_le_q)
  );
  hyst_compare #(.MODE(CMP_GT)) u_cmp_gt (
    .clock      (clock),
    .rst_sync_n (rst_sync_n),
    .clear      (block_clear),
    .args       (gt_args),
    .hit_q      (cmp_gt_q)
  );
  hyst_compare #(.MODE(CMP_LT)) u_cmp_lt (
    .clock      (clock),
    .rst_sync_n (rst_sync_n),
    .clear      (block_clear),
    .args       (lt_args),
    .hit_q      (cmp_lt_q)
  );
  hyst_compare #(.MODE(CMP_EQ)) u_cmp_eq (
    .clock      (clock),
    .rst_sync_n (rst_sync_n),
    .clear      (block_clear),
    .args       (eq_args),
    .hit_q      (cmp_eq_q)
  );

  // ****************************************************************
  // Up counter
  // ****************************************************************
  logic cnt_prev_q;
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cnt_prev_q <= 1'b0;
    end else if (block_clear) begin
      cnt_prev_q <= 1'b0;
    end else begin
      cnt_prev_q <= cnt_pulse;
    end
  end
  // The count wraps at its width; reset wins over a coincident edge.
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      count_q <= CNT_ZERO;
    end else if (block_clear || cnt_reset) begin
      count_q <= CNT_ZERO;
    end else if (cnt_pulse && !cnt_prev_q) begin
      count_q <= count_q + 16'h0001;
    end
  end
  a_cnt_edge: assert property (@(posedge clock) disable iff (!rst_sync_n)
    !block_clear && !cnt_reset && cnt_pulse && !cnt_prev_q
    |=> count_q == $past(count_q) + 16'h0001)
    else $error("counter missed an edge");
  a_cnt_reset: assert property (@(posedge clock) disable iff (!rst_sync_n)
    cnt_reset |=> count_q == CNT_ZERO)
    else $error("counter not cleared");
  a_cnt_steady: assert property (@(posedge clock) disable iff (!rst_sync_n)
    !block_clear && !cnt_reset && !(cnt_pulse && !cnt_prev_q)
    |=> $stable(count_q))
    else $error("counter moved without an edge");

  // ****************************************************************
  // On/off delay timer
  // ****************************************************************
  tmr_state_type       tmr_state_q;
  logic [DLY_W-1:0]    tmr_cnt_q;
  logic [DLY_W-1:0]    tmr_next;
  assign tmr_next = tmr_cnt_q + 16'h0001;
  // An input pulse shorter than the on delay never reaches the output.
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tmr_state_q <= TMR_IDLE;
      tmr_cnt_q   <= CNT_ZERO;
      tmr_out_q   <= 1'b0;
    end else if (block_clear) begin
      tmr_state_q <= TMR_IDLE;
      tmr_cnt_q   <= CNT_ZERO;
      tmr_out_q   <= 1'b0;
    end else begin
      unique case (tmr_state_q)
        TMR_IDLE: begin
          tmr_cnt_q <= CNT_ZERO;
          if (tmr_in) begin
            tmr_state_q <= TMR_ON_WAIT;
          end
        end
        TMR_ON_WAIT: begin
          if (!tmr_in) begin
            tmr_state_q <= TMR_IDLE;
          end else if (tmr_next >= tmr_on_delay) begin
            tmr_state_q <= TMR_ON;
            tmr_out_q   <= 1'b1;
          end else begin
            tmr_cnt_q <= tmr_next;
          end
        end
        TMR_ON: begin
          tmr_cnt_q <= CNT_ZERO;
          if (!tmr_in) begin
            tmr_state_q <= TMR_OFF_WAIT;
          end
        end
        TMR_OFF_WAIT: begin
          if (tmr_in) begin
            tmr_state_q <= TMR_ON;
            tmr_cnt_q   <= CNT_ZERO;
          end else if (tmr_next >= tmr_off_delay) begin
            tmr_state_q <= TMR_IDLE;
            tmr_out_q   <= 1'b0;
          end else begin
            tmr_cnt_q <= tmr_next;
          end
        end
        default: begin
          tmr_state_q <= TMR_IDLE;
          tmr_cnt_q   <= CNT_ZERO;
          tmr_out_q   <= 1'b0;
        end
      endcase
    end
  end

  a_tmr_rise: assert property (@(posedge clock) disable iff (!rst_sync_n)
    $rose(tmr_out_q) |-> $past(tmr_in) && $past(tmr_state_q) == TMR_ON_WAIT)
    else $error("timer rose without on delay");
  a_tmr_fall: assert property (@(posedge clock) disable iff (!rst_sync_n)
    $fell(tmr_out_q) && !$past(block_clear)
    |-> !$past(tmr_in) && $past(tmr_state_q) == TMR_OFF_WAIT)
    else $error("timer fell without off delay");

  // ****************************************************************
  // Residue, round and selector
  // ****************************************************************
  logic [FIX_W-1:0] res_mag;
  logic [FIX_W-1:0] res_frac;
  logic [FIX_W-1:0] rnd_mag;
  logic [FIX_W-1:0] rnd_sum;
  logic [FIX_W-1:0] rnd_whole;
  // Negative inputs keep their sign, so -1.5 rounds to -2.
  always_comb begin
    res_mag   = res_in[FIX_W-1] ? 32'(-res_in) : 32'(res_in);
    res_frac  = res_mag & FRAC_MASK;
    rnd_mag   = rnd_in[FIX_W-1] ? 32'(-rnd_in) : 32'(rnd_in);
    rnd_sum   = rnd_mag + HALF_UNIT;
    rnd_whole = rnd_sum & ~FRAC_MASK;
  end
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      res_out_q <= '0;
      rnd_out_q <= '0;
      sel_out_q <= '0;
    end else if (block_clear) begin
      res_out_q <= '0;
      rnd_out_q <= '0;
      sel_out_q <= '0;
    end else begin
      res_out_q <= res_in[FIX_W-1] ? -$signed(res_frac) : $signed(res_frac);
      rnd_out_q <= rnd_in[FIX_W-1] ? -$signed(rnd_whole)
                                   : $signed(rnd_whole);
      sel_out_q <= sel_pick ? sel_b : sel_a;
    end
  end

  a_res_frac: assert property (@(posedge clock) disable iff (!rst_sync_n)
    !block_clear |=> (res_out_q[FIX_W-1] ? 32'(-res_out_q) : 32'(res_out_q))
    == ((($past(res_in[FIX_W-1]) ? 32'(-$past(res_in)) : 32'($past(res_in)))
    & FRAC_MASK)))
    else $error("residue kept whole part");
  a_rnd_whole: assert property (@(posedge clock) disable iff (!rst_sync_n)
    !block_clear |=> (rnd_out_q & FRAC_MASK) == 32'h0)
    else $error("rounded value has fraction");
  a_sel_pass: assert property (@(posedge clock) disable iff (!rst_sync_n)
    !block_clear |=> sel_out_q == ($past(sel_pick) ? $past(sel_b)
                                                    : $past(sel_a)))
    else $error("selector passed wrong input");

  // ****************************************************************
  // Virtual event input and output
  // ****************************************************************
  // The watched code is matched against one reported code per tick.
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      evt_raise_q <= 1'b0;
      evt_code_q  <= '0;
      mon_hit_q   <= 1'b0;
    end else if (block_clear) begin
      evt_raise_q <= 1'b0;
      evt_code_q  <= '0;
      mon_hit_q   <= 1'b0;
    end else begin
      evt_raise_q <= evt_in;
      evt_code_q  <= evt_in ? evt_code : '0;
      mon_hit_q   <= seen_valid && (seen_code == mon_code);
    end
  end

  a_evt_raise: assert property (@(posedge clock) disable iff (!rst_sync_n)
    !block_clear && evt_in |=> evt_raise_q && evt_code_q == $past(evt_code))
    else $error("event code not raised");
  a_mon_hit: assert property (@(posedge clock) disable iff (!rst_sync_n)
    !block_clear |=> mon_hit_q == ($past(seen_valid)
                    && $past(seen_code) == $past(mon_code)))
    else $error("event match wrong");

  // ****************************************************************
  // Calendar comparators
  // ****************************************************************
  // Masking both sides with the same field set leaves only used fields.
  function automatic logic [DATE_KEY_W-1:0] date_key(input date_type d,
                                                      input logic [5:0] u);
    date_key = {d.year & {12{u[5]}}, d.month & {4{u[4]}},
                d.day & {5{u[3]}}, d.hour & {5{u[2]}},
                d.minute & {6{u[1]}}, d.second & {6{u[0]}}};
  endfunction
  logic [DATE_KEY_W-1:0] aoa_now;
  logic [DATE_KEY_W-1:0] aoa_set;
  logic [DATE_KEY_W-1:0] aob_now;
  logic [DATE_KEY_W-1:0] aob_set;
  logic [DATE_KEY_W-1:0] sa_now;
  logic [DATE_KEY_W-1:0] sa_set;
  always_comb begin
    aoa_now = date_key(rtc_now, aoa_cfg.used);
    aoa_set = date_key(aoa_cfg.value, aoa_cfg.used);
    aob_now = date_key(rtc_now, aob_cfg.used);
    aob_set = date_key(aob_cfg.value, aob_cfg.used);
    sa_now  = date_key(rtc_now, sa_cfg.used);
    sa_set  = date_key(sa_cfg.value, sa_cfg.used);
  end
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      date_at_or_after_q    <= 1'b0;
      date_at_or_before_q   <= 1'b0;
      date_strictly_after_q <= 1'b0;
    end else if (block_clear) begin
      date_at_or_after_q    <= 1'b0;
      date_at_or_before_q   <= 1'b0;
      date_strictly_after_q <= 1'b0;
    end else begin
      date_at_or_after_q    <= aoa_now >= aoa_set;
      date_at_or_before_q   <= aob_now <= aob_set;
      date_strictly_after_q <= sa_now > sa_set;
    end
  end

  a_date_aoa: assert property (@(posedge clock) disable iff (!rst_sync_n)
    !block_clear |=> date_at_or_after_q == $past(aoa_now >= aoa_set))
    else $error("at-or-after date wrong");
  a_date_aob: assert property (@(posedge clock) disable iff (!rst_sync_n)
    !block_clear |=> date_at_or_before_q == $past(aob_now <= aob_set))
    else $error("at-or-before date wrong");
  a_date_sa: assert property (@(posedge clock) disable iff (!rst_sync_n)
    !block_clear |=> date_strictly_after_q == $past(sa_now > sa_set))
    else $error("strictly-after date wrong");
  a_date_unused: assert property (@(posedge clock) disable iff (!rst_sync_n)
    !block_clear && aoa_cfg.used == 6'h00 |=> date_at_or_after_q)
    else $error("unused fields took part");
  a_clear_all: assert property (@(posedge clock) disable iff (!rst_sync_n)
    block_clear |=> count_q == CNT_ZERO && !tmr_out_q && !cmp_le_q
    && !cmp_eq_q && !evt_raise_q && !date_strictly_after_q)
    else $error("clear left state");

endmodule // logic_function_blocks
`default_nettype wire

// ==== test/testbench.sv ====
// Random self-checking testbench for the user logic function blocks.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import logic_blocks_pkg::*;
  logic         clock = 1'b0, rst_n, block_clear, cnt_pulse, cnt_reset;
  logic         tmr_in, sel_pick, evt_in, seen_valid, tmr_out_q, mon_hit_q;
  logic         cmp_le_q, cmp_gt_q, cmp_lt_q, cmp_eq_q, evt_raise_q;
  logic         date_at_or_after_q, date_at_or_before_q;
  logic         date_strictly_after_q;
  logic [15:0]  count_q, tmr_on_delay, tmr_off_delay;
  cmp_args_type le_args, gt_args, lt_args, eq_args;
  fix_type      res_in, res_out_q, rnd_in, rnd_out_q, sel_a, sel_b, sel_out_q;
  dtc_type      evt_code, evt_code_q, mon_code, seen_code;
  date_type     rtc_now;
  date_cfg_type aoa_cfg, aob_cfg, sa_cfg;
  logic [3:0]   e_cmp;
  logic [15:0]  e_cnt;
  logic         prev, e_tmr, e_er, e_mh;
  logic [2:0]   e_dt;
  fix_type      e_res, e_rnd, e_sel;
  dtc_type      e_ec;
  int           tst, tc, mismatches = 0, n_tests = 0, seed = 32'h629f3e7c;

  logic_function_blocks dut (.clock, .rst_n, .block_clear, .le_args,
    .gt_args, .lt_args, .eq_args, .cmp_le_q, .cmp_gt_q, .cmp_lt_q, .cmp_eq_q,
    .cnt_pulse, .cnt_reset, .count_q, .tmr_in, .tmr_on_delay, .tmr_off_delay,
    .tmr_out_q, .res_in, .res_out_q, .rnd_in, .rnd_out_q, .sel_a, .sel_b,
    .sel_pick, .sel_out_q, .evt_in, .evt_code, .evt_raise_q, .evt_code_q,
    .mon_code, .seen_code, .seen_valid, .mon_hit_q, .rtc_now, .aoa_cfg,
    .aob_cfg, .sa_cfg, .date_at_or_after_q, .date_at_or_before_q,
    .date_strictly_after_q);

  always #5 clock = ~clock;

  // ****************************************************************
  // Expectation model
  // ****************************************************************
  // Operands stay non-negative so that set and release never overlap.
  function automatic logic cmp_next(int m, logic h, cmp_args_type a);
    longint x, y, p;
    x = 100 * longint'(a.in1);
    y = longint'(a.in2);
    p = (a.hyst_pct > 7'h64) ? 100 : longint'(a.hyst_pct);
    case (m)
      0: return (a.in1 <= a.in2) | (h & !(x > y * (100 + p)));
      1: return (a.in1 > a.in2) | (h & !(x < y * (100 - p)));
      2: return (a.in1 < a.in2) | (h & !(x > y * (100 + p)));
      default: return (a.in1 == a.in2)
        | (h & !(x > y * (100 + p)) & !(x < y * (100 - p)));
    endcase
  endfunction

  function automatic logic [37:0] key(date_type d, logic [5:0] u);
    return {d.year & {12{u[5]}}, d.month & {4{u[4]}}, d.day & {5{u[3]}},
            d.hour & {5{u[2]}}, d.minute & {6{u[1]}}, d.second & {6{u[0]}}};
  endfunction

  function automatic fix_type frac(fix_type x);
    return (x < 0) ? -((-x) & FRAC_MASK) : (x & FRAC_MASK);
  endfunction

  function automatic fix_type round_near(fix_type x);
    return (x < 0) ? -(((-x) + HALF_UNIT) & ~FRAC_MASK)
                   : ((x + HALF_UNIT) & ~FRAC_MASK);
  endfunction

  task automatic step();
    int lon, lof;
    lon = (tmr_on_delay == 0) ? 1 : int'(tmr_on_delay);
    lof = (tmr_off_delay == 0) ? 1 : int'(tmr_off_delay);
    if (block_clear) begin
      {e_cmp, e_cnt, prev, e_tmr, e_er, e_mh, e_dt, e_ec} = '0;
      {e_res, e_rnd, e_sel} = '0;
      tst = 0;
      return;
    end
    e_cmp = {cmp_next(3, e_cmp[3], eq_args), cmp_next(2, e_cmp[2], lt_args),
             cmp_next(1, e_cmp[1], gt_args), cmp_next(0, e_cmp[0], le_args)};
    e_cnt = cnt_reset ? 16'h0000 : e_cnt + 16'(cnt_pulse & !prev);
    prev = cnt_pulse;
    case (tst)
      0: if (tmr_in) begin tst = 1; tc = 0; end
      1: if (!tmr_in) tst = 0;
         else if (tc + 1 >= lon) begin tst = 2; e_tmr = 1'b1; end
         else tc = tc + 1;
      2: if (!tmr_in) begin tst = 3; tc = 0; end
      default: if (tmr_in) tst = 2;
         else if (tc + 1 >= lof) begin tst = 0; e_tmr = 1'b0; end
         else tc = tc + 1;
    endcase
    e_res = frac(res_in);
    e_rnd = round_near(rnd_in);
    e_sel = sel_pick ? sel_b : sel_a;
    e_er = evt_in;
    e_ec = evt_in ? evt_code : '0;
    e_mh = seen_valid && (seen_code == mon_code);
    e_dt = {key(rtc_now, sa_cfg.used) > key(sa_cfg.value, sa_cfg.used),
            key(rtc_now, aob_cfg.used) <= key(aob_cfg.value, aob_cfg.used),
            key(rtc_now, aoa_cfg.used) >= key(aoa_cfg.value, aoa_cfg.used)};
  endtask

  // ****************************************************************
  // Stimulus and checks
  // ****************************************************************
  function automatic cmp_args_type rargs(logic [31:0] r);
    return '{32'({r[4:0], 15'h0}), 32'({r[8:5], 16'h0}), r[15:9]};
  endfunction

  function automatic date_type rdate(logic [31:0] r);
    return '{12'h7df + 12'(r[0]), 4'(r[2:1]), 5'(r[4:3]), 5'(r[6:5]),
             6'(r[8:7]), 6'(r[10:9])};
  endfunction

  task automatic drive(logic hold);
    logic [31:0] r, q;
    r = $random(seed);
    q = $random(seed);
    {cnt_pulse, evt_in, sel_pick, seen_valid} = r[3:0];
    cnt_reset = (r[8:4] == 0);
    block_clear = hold || (r[14:9] == 0);
    if (r[17:15] == 0) tmr_in = !tmr_in;
    // Delays only move while the timer idles, so no wait sees two values.
    if (tst == 0 && !tmr_in) {tmr_on_delay, tmr_off_delay} = {13'h0,
      q[2:0], 13'h0, q[5:3]};
    if (q[7:6] == 0) le_args = rargs($random(seed));
    if (q[9:8] == 0) gt_args = rargs($random(seed));
    if (q[11:10] == 0) lt_args = rargs($random(seed));
    if (q[13:12] == 0) eq_args = rargs($random(seed));
    res_in = $random(seed) >>> 1;
    rnd_in = $random(seed) >>> 1;
    if (q[14]) rnd_in[14:0] = '0;
    {sel_a, sel_b} = {$random(seed), $random(seed)};
    evt_code = dtc_type'(24'($random(seed)));
    seen_code = '{19'(r[19:18]), 5'(r[20])};
    mon_code = '{19'(r[22:21]), 5'(r[23])};
    rtc_now = rdate($random(seed));
    aoa_cfg = '{rdate($random(seed)), 6'($random(seed))};
    aob_cfg = '{rdate($random(seed)), 6'($random(seed))};
    sa_cfg = '{rdate($random(seed)), 6'($random(seed))};
  endtask

  task automatic chk(logic [63:0] got, logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    if (mismatches == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #70000;
    mismatches++;
    give_verdict();
  end

  initial begin
    {rst_n, cnt_pulse, cnt_reset, tmr_in, sel_pick, evt_in, seen_valid} = '0;
    {le_args, gt_args, lt_args, eq_args, res_in, rnd_in, sel_a, sel_b} = '0;
    {tmr_on_delay, tmr_off_delay, evt_code, mon_code, seen_code} = '0;
    {rtc_now, aoa_cfg, aob_cfg, sa_cfg} = '0;
    block_clear = 1'b1;
    step();
    for (int i = 0; i < 6000; i++) begin
      @(negedge clock);
      if (i > 0) begin
        chk(cmp_le_q, e_cmp[0]);
        chk(cmp_gt_q, e_cmp[1]);
        chk(cmp_lt_q, e_cmp[2]);
        chk(cmp_eq_q, e_cmp[3]);
        chk(count_q, e_cnt);
        chk(tmr_out_q, e_tmr);
        chk(res_out_q, e_res);
        chk(rnd_out_q, e_rnd);
        chk(sel_out_q, e_sel);
        chk({evt_raise_q, evt_code_q}, {e_er, e_ec});
        chk(mon_hit_q, e_mh);
        chk(date_at_or_after_q, e_dt[0]);
        chk(date_at_or_before_q, e_dt[1]);
        chk(date_strictly_after_q, e_dt[2]);
      end
      drive(i < 8 || (i >= 3000 && i < 3008));
      // A second reset lands in mid-run with traffic live around it.
      rst_n = !(i < 5 || (i >= 3000 && i < 3005));
      step();
    end
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
